// *** rtl/sscp_pkg.sv ***
// Shared constants and types of the stepper serial control port.
// Assumes a 20 MHz core clock; all cycle counts below derive from it.
package sscp_pkg;

   // ******************************************
   // Control word
   // ******************************************
   localparam int WORD_BITS = 12;
   localparam logic [11:0] WORD_RESET = 12'h000;

   // One phase of the control word, top bit first: mixed decay, current code, polarity
   typedef struct packed {
      logic mixed;
      logic [3:0] dac;
      logic pol;
   } sscp_phase_s;

   // Phase A occupies the upper half of the word, phase B the lower half
   typedef struct packed {
      sscp_phase_s a;
      sscp_phase_s b;
   } sscp_word_s;

   // ******************************************
   // Timing
   // ******************************************
   localparam int CORE_CLK_MHZ = 20;
   localparam int POL_DELAY_US = 3;
   localparam int POL_CYCLES = POL_DELAY_US * CORE_CLK_MHZ;
   localparam int BLANK_NS = 1500;
   localparam int BLANK_CYCLES = (BLANK_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int CHOP_PERIOD_US = 40;
   localparam int CHOP_CYCLES = CHOP_PERIOD_US * CORE_CLK_MHZ;
   localparam int FAST_DECAY_CYCLES = CHOP_CYCLES / 4;

   // ******************************************
   // Bridge output codes
   // ******************************************
   localparam logic [1:0] BRIDGE_FLOAT = 2'h0;
   localparam logic [1:0] BRIDGE_POS = 2'h1;
   localparam logic [1:0] BRIDGE_NEG = 2'h2;
   localparam logic [1:0] BRIDGE_SLOW = 2'h3;

endpackage

// *** rtl/sscp_chopper.sv ***
// One phase of the fixed-period style chopper behind the serial port.
// Assumes a synchronised active-low reset and a sense comparator level from a pin.
module sscp_chopper #(
   parameter int PERIOD = sscp_pkg::CHOP_CYCLES,
   parameter int BLANK = sscp_pkg::BLANK_CYCLES,
   parameter int FAST = sscp_pkg::FAST_DECAY_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic enable,
   input wire sscp_pkg::sscp_phase_s cfg,
   input wire logic sense_pin,
   output logic [1:0] bridge
);

   localparam int CW = $clog2(PERIOD) + 1;

   typedef enum {CH_OFF, CH_BLANK, CH_ON, CH_DECAY} sscp_chop_e;

   sscp_chop_e state;
   sscp_chop_e next_state;
   logic [1:0] next_bridge;
   logic sense_s1;
   logic sense_s2;
   logic [CW-1:0] cnt;
   logic [CW-1:0] tmr;
   logic [CW-1:0] next_tmr;
   logic period_start;
   logic [1:0] drive;

   // ******************************************
   // Sense synchroniser and period counter
   // ******************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_s1 <= 1'b0;
         sense_s2 <= 1'b0;
      end else begin
         sense_s1 <= sense_pin;
         sense_s2 <= sense_s1;
      end
   end

   // A polarity change restarts only this phase's period
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (restart || cnt == CW'(PERIOD - 1)) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   assign period_start = restart || cnt == CW'(PERIOD - 1);
   assign drive = cfg.pol ? sscp_pkg::BRIDGE_NEG : sscp_pkg::BRIDGE_POS;

   // ******************************************
   // Chopper state machine
   // ******************************************
   always_comb begin
      next_state = state;
      next_tmr = tmr;
      if (!enable || cfg.dac == 4'h0) begin
         next_state = CH_OFF;
         next_tmr = '0;
      end else if (period_start) begin
         // Current already above threshold: skip the on-time of this period
         next_state = sense_s2 ? CH_DECAY : CH_BLANK;
         next_tmr = '0;
      end else begin
         case (state)
            CH_BLANK: begin
               if (tmr == CW'(BLANK - 1)) begin
                  next_state = CH_ON;
                  next_tmr = '0;
               end else begin
                  next_tmr = tmr + 1'b1;
               end
            end
            CH_ON: begin
               if (sense_s2) begin
                  next_state = CH_DECAY;
                  next_tmr = '0;
               end
            end
            CH_DECAY: begin
               if (tmr != CW'(FAST)) begin
                  next_tmr = tmr + 1'b1;
               end
            end
            CH_OFF: next_state = CH_OFF;
            default: next_state = CH_OFF;
         endcase
      end
      case (next_state)
         CH_BLANK: next_bridge = drive;
         CH_ON: next_bridge = drive;
         CH_DECAY: begin
            // Mixed decay spends the first part of the off-time in fast decay
            if (cfg.mixed && next_tmr < CW'(FAST)) begin
               next_bridge = sscp_pkg::BRIDGE_FLOAT;
            end else begin
               next_bridge = sscp_pkg::BRIDGE_SLOW;
            end
         end
         default: next_bridge = sscp_pkg::BRIDGE_FLOAT;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CH_OFF;
         tmr <= '0;
         bridge <= sscp_pkg::BRIDGE_FLOAT;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         bridge <= next_bridge;
      end
   end

   // ******************************************
   // Checks
   // ******************************************
   a_zero_code_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.dac == 4'h0) |=> (bridge == sscp_pkg::BRIDGE_FLOAT))
      else $error("coil not off with zero current code");

   a_start_sense_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (period_start && sense_s2 && enable && cfg.dac != 4'h0)
      |=> (bridge == sscp_pkg::BRIDGE_FLOAT || bridge == sscp_pkg::BRIDGE_SLOW))
      else $error("bridge switched on although sense tripped at period start");

   a_restart_blank: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (restart && enable && cfg.dac != 4'h0 && !sense_s2)
      |=> (state == CH_BLANK && bridge == $past(drive)))
      else $error("chopper not restarted into blanking");

endmodule

// *** rtl/sscp_serial_port.sv ***
// Serial control port of a dual full-bridge stepper driver, with both phase choppers.
// Assumes the host keeps the link clock still while chip select is high, and that
// chip select then stays high for at least four core cycles.
//
// Functional notes
// - Bits shifted in on the serial input leave on the serial output, so devices can chain.
// - In a 16-bit frame the first four bits are dummies and only the last twelve are used.
// - A frame with fewer than twelve clock bits is discarded and the old settings stay.
// - The serial output is high impedance while the enable pin or chip select is high.
// - A new word that changes a phase polarity restarts that phase's chopper only.
// - A chopper period starting with the sense comparator tripped keeps the bridge off.
// - A changed polarity reaches the bridge typically 3 us after chip select rises.
// - A zero current code switches the coil off completely.
module sscp_serial_port #(
   parameter int POL_DELAY = sscp_pkg::POL_CYCLES,
   parameter int CHOP_PERIOD = sscp_pkg::CHOP_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic link_sck,
   input wire logic chip_select_low,
   input wire logic link_data_in,
   output logic link_data_out,
   output logic link_data_out_oe,
   input wire logic enable_low_pin,
   input wire logic phase_a_sense_input,
   input wire logic phase_b_sense_input,
   output logic [1:0] bridge_a_outputs,
   output logic [1:0] bridge_b_outputs,
   output logic phase_a_polarity,
   output logic phase_b_polarity,
   output logic phase_a_mixed_decay,
   output logic phase_b_mixed_decay,
   output logic [3:0] phase_a_current_code,
   output logic [3:0] phase_b_current_code,
   output logic word_accepted
);

   localparam int WB = sscp_pkg::WORD_BITS;
   localparam logic [3:0] FULL_COUNT = 4'(sscp_pkg::WORD_BITS);
   localparam int PW = $clog2(POL_DELAY) + 1;
   localparam int PD = POL_DELAY;

   logic rst_s1;
   logic rst_n;
   logic [WB-1:0] shift;
   logic [3:0] bit_count;
   logic frame_fresh;
   logic frame_tog;
   logic seen_tog;
   logic cs_s1;
   logic cs_s2;
   logic cs_prev;
   logic en_s1;
   logic en_s2;
   logic cs_rise;
   logic take;
   logic enough;
   sscp_pkg::sscp_word_s active;
   logic [1:0] new_pol;
   logic [1:0] applied_pol;
   logic [1:0] restart;
   sscp_pkg::sscp_phase_s cfg_a;
   sscp_pkg::sscp_phase_s cfg_b;

   // ******************************************
   // Reset release
   // ******************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ******************************************
   // Link clock domain
   // ******************************************
   // Held set while chip select is high, so the first edge of a frame sees it
   // without needing any link clock edge outside the frame
   always_ff @(posedge link_sck or posedge chip_select_low or negedge nrst) begin
      if (!nrst) begin
         frame_fresh <= 1'b1;
      end else if (chip_select_low) begin
         frame_fresh <= 1'b1;
      end else begin
         frame_fresh <= 1'b0;
      end
   end

   // Flips once per frame that saw a clock edge; without it a bare chip select
   // pulse would find the old full count and load the old bits again
   always_ff @(posedge link_sck or negedge nrst) begin
      if (!nrst) begin
         frame_tog <= 1'b0;
      end else if (!chip_select_low && frame_fresh) begin
         frame_tog <= !frame_tog;
      end
   end

   // The last twelve bits survive, so leading dummy bits simply fall out
   always_ff @(posedge link_sck or negedge nrst) begin
      if (!nrst) begin
         shift <= sscp_pkg::WORD_RESET;
      end else if (!chip_select_low) begin
         shift <= {shift[WB-2:0], link_data_in};
      end
   end

   // Saturating count of bits in the current frame
   always_ff @(posedge link_sck or negedge nrst) begin
      if (!nrst) begin
         bit_count <= 4'h0;
      end else if (!chip_select_low) begin
         if (frame_fresh) begin
            bit_count <= 4'h1;
         end else if (bit_count != FULL_COUNT) begin
            bit_count <= bit_count + 4'h1;
         end
      end
   end

   // Changing on the falling edge gives the next device a full half period of setup
   always_ff @(negedge link_sck or negedge nrst) begin
      if (!nrst) begin
         link_data_out <= 1'b0;
      end else begin
         link_data_out <= shift[WB-1];
      end
   end

   // ******************************************
   // Pin synchronisers
   // ******************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_prev <= 1'b1;
         en_s1 <= 1'b1;
         en_s2 <= 1'b1;
      end else begin
         cs_s1 <= chip_select_low;
         cs_s2 <= cs_s1;
         cs_prev <= cs_s2;
         en_s1 <= enable_low_pin;
         en_s2 <= en_s1;
      end
   end

   assign cs_rise = cs_s2 && !cs_prev;

   // Output enable lags the pins by the synchroniser; the first output bit of a
   // frame is valid only once chip select has been low for three core cycles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_data_out_oe <= 1'b0;
      end else begin
         link_data_out_oe <= !cs_s2 && !en_s2;
      end
   end

   // ******************************************
   // Frame acceptance
   // ******************************************
   // Shift and count are read across domains without a handshake: they are
   // quiet because the link clock stands still while chip select is high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_tog <= 1'b0;
      end else if (take) begin
         seen_tog <= frame_tog;
      end
   end

   assign enough = bit_count == FULL_COUNT && frame_tog != seen_tog;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         take <= 1'b0;
      end else begin
         take <= cs_rise;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         active <= sscp_pkg::WORD_RESET;
         word_accepted <= 1'b0;
      end else begin
         word_accepted <= take && enough && !en_s2;
         if (take && enough && !en_s2) begin
            active <= shift;
         end
      end
   end

   assign phase_a_mixed_decay = active.a.mixed;
   assign phase_b_mixed_decay = active.b.mixed;
   assign phase_a_current_code = active.a.dac;
   assign phase_b_current_code = active.b.dac;
   assign phase_a_polarity = applied_pol[0];
   assign phase_b_polarity = applied_pol[1];

   // ******************************************
   // Polarity update per phase
   // ******************************************
   assign new_pol = {active.b.pol, active.a.pol};
   assign cfg_a = '{mixed: active.a.mixed, dac: active.a.dac, pol: applied_pol[0]};
   assign cfg_b = '{mixed: active.b.mixed, dac: active.b.dac, pol: applied_pol[1]};

   for (genvar i = 0; i < 2; i++) begin : g_pol
      logic [PW-1:0] wait_cnt;

      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            applied_pol[i] <= 1'b0;
            wait_cnt <= '0;
            restart[i] <= 1'b0;
         end else begin
            restart[i] <= 1'b0;
            if (new_pol[i] != applied_pol[i]) begin
               if (wait_cnt == PW'(POL_DELAY - 1)) begin
                  applied_pol[i] <= new_pol[i];
                  restart[i] <= 1'b1;
                  wait_cnt <= '0;
               end else begin
                  wait_cnt <= wait_cnt + 1'b1;
               end
            end else begin
               wait_cnt <= '0;
            end
         end
      end

      a_pol_delay_bound: assert property (
         @(posedge core_clk) disable iff (!rst_n)
         $rose(new_pol[i] != applied_pol[i]) |-> ##[1:PD] (new_pol[i] == applied_pol[i]))
         else $error("polarity change not applied in time");

      a_pol_restart_pair: assert property (
         @(posedge core_clk) disable iff (!rst_n)
         $changed(applied_pol[i]) |-> (restart[i] && !$past(restart[i])))
         else $error("polarity changed without a chopper restart");
   end

   // ******************************************
   // Choppers
   // ******************************************
   sscp_chopper #(
      .PERIOD(CHOP_PERIOD),
      .BLANK(sscp_pkg::BLANK_CYCLES),
      .FAST(CHOP_PERIOD / 4)
   ) u_chop_a (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .restart(restart[0]),
      .enable(!en_s2),
      .cfg(cfg_a),
      .sense_pin(phase_a_sense_input),
      .bridge(bridge_a_outputs)
   );

   sscp_chopper #(
      .PERIOD(CHOP_PERIOD),
      .BLANK(sscp_pkg::BLANK_CYCLES),
      .FAST(CHOP_PERIOD / 4)
   ) u_chop_b (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .restart(restart[1]),
      .enable(!en_s2),
      .cfg(cfg_b),
      .sense_pin(phase_b_sense_input),
      .bridge(bridge_b_outputs)
   );

   // ******************************************
   // Checks
   // ******************************************
   a_out_tristate: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (cs_s2 || en_s2) |=> !link_data_out_oe)
      else $error("serial output driven while disabled or deselected");

   a_short_frame_kept: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (cs_rise ##1 !enough) |=> $stable(active))
      else $error("short frame changed the settings");

   a_load_on_release: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $changed(active) |-> ($past(take) && $past(cs_s2)))
      else $error("settings changed outside a chip select release");

   a_last_twelve: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (take && enough && !en_s2) |=> (active == $past(shift) && word_accepted))
      else $error("accepted word differs from the last twelve bits");

   a_shift_chain: assert property (
      @(posedge link_sck) disable iff (!nrst)
      !chip_select_low |=> (shift[WB-1:1] == $past(shift[WB-2:0])))
      else $error("shift register did not move towards the serial output");

endmodule

// *** testbench/sscp_host_model.sv ***
// Behavioural host that acts as serial bus master for the stepper control port.
// Assumes one device on its own chip select; the link clock only runs inside frames.
module sscp_host_model (
   output logic link_sck,
   output logic chip_select_low,
   output logic link_data_in,
   input wire logic link_data_line
);
   timeunit 1ns;
   timeprecision 100ps;

   // ******************************************
   // Frame driver
   // ******************************************
   logic [31:0] seen;

   initial begin
      link_sck = 1'b0;
      chip_select_low = 1'b1;
      link_data_in = 1'b0;
      seen = 32'h0;
   end

   // MSB first; read data is taken on the same rising edge that shifts ours in
   // Gap before the frame, so the caller can watch for the load pulse at once
   task automatic send(input logic [31:0] bits, input int n);
      #300;
      chip_select_low = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         link_data_in = bits[i];
         #62.5;
         link_sck = 1'b1;
         seen = {seen[30:0], link_data_line};
         #62.5;
         link_sck = 1'b0;
      end
      #100;
      chip_select_low = 1'b1;
      // Line not sampled any more, so show the opposite of the last bit
      link_data_in = ~link_data_in;
   endtask
endmodule

// *** testbench/stepper_serial_control_port_tb.sv ***
// Self-checking bench for the stepper serial control port.
// Assumes the host model above drives the link and small chopper counts.
module stepper_serial_control_port_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ******************************************
   // Clock, reset and wiring
   // ******************************************
   localparam int POLD = 8;
   localparam int PER = 64;
   logic core_clk, nrst, enable_low_pin, sense_a, sense_b;
   logic sck, csl, sdi, sdo, sdo_oe, pol_a, pol_b, mix_a, mix_b, acc;
   logic [1:0] br_a, br_b;
   logic [3:0] code_a, code_b;
   wire sdo_line = sdo_oe ? sdo : 1'bz;
   int miscompares = 0;
   int samples_checked = 0;

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   sscp_serial_port #(.POL_DELAY(POLD), .CHOP_PERIOD(PER)) i_dut (
      .core_clk(core_clk), .nrst(nrst), .link_sck(sck), .chip_select_low(csl),
      .link_data_in(sdi), .link_data_out(sdo), .link_data_out_oe(sdo_oe),
      .enable_low_pin(enable_low_pin), .phase_a_sense_input(sense_a),
      .phase_b_sense_input(sense_b), .bridge_a_outputs(br_a), .bridge_b_outputs(br_b),
      .phase_a_polarity(pol_a), .phase_b_polarity(pol_b), .phase_a_mixed_decay(mix_a),
      .phase_b_mixed_decay(mix_b), .phase_a_current_code(code_a),
      .phase_b_current_code(code_b), .word_accepted(acc));

   sscp_host_model i_host (.link_sck(sck), .chip_select_low(csl), .link_data_in(sdi),
      .link_data_line(sdo_line));

   // ******************************************
   // Helpers
   // ******************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Bounded wait for the load pulse, sampled away from the launching edge
   task automatic wait_acc(output logic got);
      got = 1'b0;
      for (int i = 0; i < 20 && !got; i++) begin
         @(negedge core_clk);
         if (acc === 1'b1) got = 1'b1;
      end
   endtask

   task automatic check_word(input sscp_pkg::sscp_word_s w);
      check({mix_a, code_a, mix_b, code_b}, {w.a.mixed, w.a.dac, w.b.mixed, w.b.dac},
         "settings");
   endtask

   // Sample both bridges for n cycles, counting the two given codes
   task automatic watch(input int n, input logic [1:0] bad1, input logic [1:0] bad2,
      output int hits);
      hits = 0;
      repeat (n) begin
         @(negedge core_clk);
         if (br_a === bad1 || br_a === bad2 || br_b === bad1 || br_b === bad2) hits++;
      end
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #2_000_000;
      miscompares++;
      wrap_up();
   end

   // ******************************************
   // Tests
   // ******************************************
   sscp_pkg::sscp_word_s w1, w2, w3;
   logic got;
   logic [1:0] dir0;
   int hits;

   initial begin
      nrst = 1'b0;
      enable_low_pin = 1'b1;
      sense_a = 1'b0;
      sense_b = 1'b0;
      w1 = '{a: '{1'b1, 4'ha, 1'b1}, b: '{1'b0, 4'h5, 1'b0}};
      w2 = '{a: '{1'b0, 4'h3, 1'b1}, b: '{1'b1, 4'hc, 1'b1}};
      w3 = '{a: '{1'b1, 4'h0, 1'b0}, b: '{1'b1, 4'h0, 1'b1}};
      tick(8);
      nrst = 1'b1;
      tick(4);
      check({sdo_oe, pol_a, code_a, br_a}, 32'h0, "reset state");
      enable_low_pin = 1'b0;
      tick(620);
      $display("Test reset done");

      i_host.send({20'h0, w1}, 12);
      wait_acc(got);
      check(got, 1'b1, "12-bit load");
      check_word(w1);
      check({pol_a, pol_b}, 2'h0, "polarity too early");
      tick(POLD + 6);
      check({pol_a, pol_b}, {w1.a.pol, w1.b.pol}, "polarity applied");
      $display("Test plain frame done");

      // Extra low current bits go out inverted: A=1 B=2 becomes /B=01 /A=10
      i_host.send({16'h0, ~2'h2, ~2'h1, w2}, 16);
      wait_acc(got);
      check(got, 1'b1, "16-bit load");
      check_word(w2);
      $display("Test long frame done");

      i_host.send({20'h0, w1}, 11);
      wait_acc(got);
      check(got, 1'b0, "short frame pulse");
      check_word(w2);
      i_host.send({20'h0, w1}, 0);
      wait_acc(got);
      check(got, 1'b0, "bare select pulse");
      check_word(w2);
      $display("Test short frame done");

      i_host.send({8'h0, w1, w2}, 24);
      check(i_host.seen[11:0], w1, "chained output");
      wait_acc(got);
      check_word(w2);
      $display("Test chain done");

      fork
         i_host.send({20'h0, w1}, 12);
         begin
            tick(20);
            check(sdo_oe, 1'b1, "drive in frame");
         end
      join
      tick(8);
      check(sdo_oe, 1'b0, "release after frame");
      enable_low_pin = 1'b1;
      tick(8);
      fork
         i_host.send({20'h0, w3}, 12);
         begin
            tick(20);
            check(sdo_oe, 1'b0, "disabled drive");
         end
      join
      wait_acc(got);
      check(got, 1'b0, "disabled load");
      tick(1);
      enable_low_pin = 1'b0;
      tick(620);
      $display("Test tristate done");

      // Sense low: each phase drives all period, direction set by polarity
      tick(2 * PER);
      dir0 = br_a;
      check(dir0 === sscp_pkg::BRIDGE_POS || dir0 === sscp_pkg::BRIDGE_NEG, 1'b1,
         "drive a");
      i_host.send({20'h0, w1.a, ~w1.b.mixed, w1.b.dac, w1.b.pol}, 12);
      tick(POLD + 12);
      check(br_a !== dir0 && (br_a === sscp_pkg::BRIDGE_POS ||
         br_a === sscp_pkg::BRIDGE_NEG), 1'b0, "a restarted");
      // Only phase A changes its polarity
      i_host.send({20'h0, w1.a.mixed, w1.a.dac, ~w1.a.pol, w1.b}, 12);
      tick(POLD + 12);
      check(br_a !== dir0 && (br_a === sscp_pkg::BRIDGE_POS ||
         br_a === sscp_pkg::BRIDGE_NEG), 1'b1, "a flipped");
      $display("Test restart done");

      sense_a = 1'b1;
      sense_b = 1'b1;
      tick(PER + 4);
      watch(2 * PER, sscp_pkg::BRIDGE_POS, sscp_pkg::BRIDGE_NEG, hits);
      check(hits, 0, "drive with sense high");
      tick(1);
      sense_a = 1'b0;
      sense_b = 1'b0;
      i_host.send({20'h0, w3}, 12);
      tick(POLD + 12);
      watch(2 * PER, sscp_pkg::BRIDGE_POS, sscp_pkg::BRIDGE_SLOW, hits);
      check(hits + (br_a !== sscp_pkg::BRIDGE_FLOAT), 0, "zero code off");
      watch(PER, sscp_pkg::BRIDGE_NEG, sscp_pkg::BRIDGE_SLOW, hits);
      check(hits + (br_b !== sscp_pkg::BRIDGE_FLOAT), 0, "zero code off b");
      $display("Test chopper done");
      wrap_up();
   end
endmodule
